/* verilog/smm_consts.svh */
// constants for the supply mode and monitor controller
// assumes inclusion by bare name from the package and the top module
`ifndef SMM_CONSTS_SVH
`define SMM_CONSTS_SVH
`define SMM_CLK_MHZ          100
`define SMM_MOD_RATE_KHZ     10
// half period of the 10 kHz modulation rate, in system clocks
`define SMM_MOD_HALF_CYC     ((`SMM_CLK_MHZ * 1000) / (`SMM_MOD_RATE_KHZ * 2))
`define SMM_SHORT_TIME_US    2000
`define SMM_SHORT_CYC        (`SMM_SHORT_TIME_US * `SMM_CLK_MHZ)
`define SMM_DEPTH_10         2'h0
`define SMM_DEPTH_20         2'h1
`define SMM_DEPTH_30         2'h2
`define SMM_THR_LOWEST       2'h0
`define SMM_ST_POWERUP       3'h0
`define SMM_ST_RESET         3'h1
`define SMM_ST_STARTUP       3'h2
`define SMM_ST_NORMAL        3'h3
`define SMM_ST_STANDBY       3'h4
`define SMM_ST_FLASH         3'h5
`define SMM_ST_SLEEP         3'h6
`define SMM_ST_FAILSAFE      3'h7
`endif

/* verilog/smm_pkg.sv */
// types for the supply mode and monitor controller
// assumes the constants header is on the include path
`include "smm_consts.svh"
package smm_pkg;
    // operating modes reported by the chip state machine
    typedef enum logic [2:0] {
        SMM_POWERUP  = 3'b000,
        SMM_RESET    = 3'b001,
        SMM_STARTUP  = 3'b010,
        SMM_NORMAL   = 3'b011,
        SMM_STANDBY  = 3'b100,
        SMM_FLASH    = 3'b101,
        SMM_SLEEP    = 3'b110,
        SMM_FAILSAFE = 3'b111
    } smm_mode_e;
    // local supply state
    typedef enum logic [1:0] {
        SMM_OFF  = 2'b00,
        SMM_ON   = 2'b01,
        SMM_FAIL = 2'b10
    } smm_pwr_e;
    // auxiliary detector status
    typedef struct packed {
        logic under;
        logic over;
    } smm_aux_s;
    // frequency modulation control
    typedef struct packed {
        logic       enable;
        logic [1:0] depth;
    } smm_fm_s;
endpackage : smm_pkg

/* verilog/smm_freq_mod.sv */
// square-wave switching frequency offset generator
// assumes a free running system clock; offset is a signed percentage
`timescale 1ns/1ps
`include "smm_consts.svh"
module smm_freq_mod #(
    parameter int HALF_CYC = `SMM_MOD_HALF_CYC
) (
    input  wire logic            SYS_CLK,
    input  wire logic            NRST,
    input  wire smm_pkg::smm_fm_s FM,
    output logic signed [5:0]    FREQ_OFFSET_PCT
);
    initial begin
        if (HALF_CYC < 2) $error("smm_freq_mod: HALF_CYC too small");
        // the half period counter is 16 bits wide
        if (HALF_CYC > 65536) $error("smm_freq_mod: HALF_CYC too large");
    end
    logic [15:0]        cnt;       // cycles inside a half period
    logic               up;        // sweep direction
    logic [15:0]        next_cnt;
    logic               next_up;
    logic signed [5:0]  next_off;
    logic signed [5:0]  lim;       // depth limit in percent

    // sweep offset between minus and plus the selected depth
    always_comb begin
        next_cnt = cnt;
        next_up  = up;
        next_off = FREQ_OFFSET_PCT;
        case (FM.depth)
            `SMM_DEPTH_10: lim = 6'sd10;
            `SMM_DEPTH_20: lim = 6'sd20;
            default:       lim = 6'sd30;
        endcase
        if (!FM.enable) begin
            // fixed frequency by default
            next_cnt = 16'h0000;
            next_up  = 1'b1;
            next_off = 6'sd0;
        end else if (cnt == 16'(HALF_CYC - 1)) begin
            next_cnt = 16'h0000;
            next_up  = ~up;
            next_off = up ? lim : -lim;
        end else begin
            next_cnt = cnt + 16'h0001;
        end
    end

    // register the sweep
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            cnt             <= 16'h0000;
            up              <= 1'b1;
            FREQ_OFFSET_PCT <= 6'sd0;
        end else begin
            cnt             <= next_cnt;
            up              <= next_up;
            FREQ_OFFSET_PCT <= next_off;
        end
    end
endmodule : smm_freq_mod

/* verilog/smm_ctrl.sv */
// supply mode and monitor controller top
// assumes comparator outputs and control bits already synchronous
`timescale 1ns/1ps
`include "smm_consts.svh"
module smm_ctrl #(
    parameter int SHORT_CYC = `SMM_SHORT_CYC
) (
    input  wire logic              SYS_CLK,
    input  wire logic              NRST,
    input  wire logic              MID_ABOVE_ON,      // mid rail over on level
    input  wire logic              MID_ABOVE_OFF,     // mid rail over off level
    input  wire smm_pkg::smm_mode_e MODE,            // chip operating mode
    input  wire logic              WAKE_FROM_SLEEP,   // level while waking
    input  wire logic              FAILSAFE_RECOVER,  // level while recovering
    input  wire logic              STEP_UP_ENABLE_BIT,
    input  wire logic              SW_DEV_CONFIG,
    input  wire logic              CFG_STRAP,
    input  wire smm_pkg::smm_fm_s  FM_CTRL,
    input  wire logic [1:0]        MAIN_RESET_THRESHOLD,
    input  wire logic [3:0]        MAIN_ABOVE_LEVEL,  // above each reset level
    input  wire logic              MAIN_ABOVE_WARN,   // above highest level
    input  wire logic              MAIN_ABOVE_SHORT,  // above short threshold
    input  wire logic              AUX_ENABLE_BIT,
    input  wire logic              AUX_UNDER_RAW,
    input  wire logic              AUX_OVER_RAW,
    input  wire logic              AUX_FLAG_CLEAR,    // one-cycle host clear
    input  wire logic              AUX_IRQ_ENABLE,
    output logic                   CORE_RUN,
    output logic                   SHUTDOWN,
    output logic                   CONV_ENABLE,
    output logic                   BOOST_ACTIVE,
    output logic signed [5:0]      FREQ_OFFSET_PCT,
    output logic                   MAIN_UNDERVOLT,    // to the state machine
    output logic                   RESET_OUT_N_OE,
    output logic                   MAIN_LOW_WARN_N_OE,
    output logic                   SHORT_FAILSAFE,
    output logic                   SHORT_CAUSE,
    output logic                   AUX_SUPPLY_ON,
    output smm_pkg::smm_aux_s      AUX_STATUS,
    output logic                   AUX_UNDER_FLAG,
    output logic                   AUX_OVER_FLAG,
    output logic                   AUX_IRQ
);
    initial begin
        if (SHORT_CYC < 1) $error("smm_ctrl: SHORT_CYC must be positive");
    end

    // returns true for reset, start-up, normal, standby and flash
    function automatic logic active_mode(input smm_pkg::smm_mode_e m);
        active_mode = (m == smm_pkg::SMM_RESET)   ||
                      (m == smm_pkg::SMM_STARTUP) ||
                      (m == smm_pkg::SMM_NORMAL)  ||
                      (m == smm_pkg::SMM_STANDBY) ||
                      (m == smm_pkg::SMM_FLASH);
    endfunction : active_mode

    smm_pkg::smm_pwr_e pwr;           // local supply state
    smm_pkg::smm_pwr_e next_pwr;
    logic              boost_held;    // boost remembered across powerup
    logic              next_boost_held;
    logic [31:0]       short_cnt;     // time below short threshold
    logic [31:0]       next_short_cnt;
    logic              next_short_cause;
    logic              next_boost;
    logic              boost_req;     // request from bit or strap
    logic              main_uv;       // below selected reset level
    logic              next_aux_on;
    smm_pkg::smm_aux_s next_status;
    logic              next_uf;
    logic              next_of;

    // supply state: run between on level and off level
    always_comb begin
        next_pwr = pwr;
        case (pwr)
            smm_pkg::SMM_OFF:
                if (MID_ABOVE_ON) next_pwr = smm_pkg::SMM_ON;
            smm_pkg::SMM_ON: begin
                if (!MID_ABOVE_OFF) next_pwr = smm_pkg::SMM_FAIL;
            end
            smm_pkg::SMM_FAIL:
                next_pwr = smm_pkg::SMM_OFF;   // one cycle of shut-down
            default: next_pwr = smm_pkg::SMM_OFF;
        endcase
    end

    // boost selection; the strap counts only in development setup
    always_comb begin
        boost_req = STEP_UP_ENABLE_BIT ||
                    (SW_DEV_CONFIG && CFG_STRAP);
        next_boost_held = boost_held;
        next_boost = 1'b0;
        if (pwr != smm_pkg::SMM_ON || WAKE_FROM_SLEEP ||
            FAILSAFE_RECOVER) begin
            next_boost      = 1'b0;
            next_boost_held = 1'b0;
        end else if (active_mode(MODE)) begin
            next_boost      = boost_req;
            next_boost_held = boost_req;
        end else if (MODE == smm_pkg::SMM_POWERUP) begin
            // under-voltage recovery keeps the previous choice
            next_boost = boost_held;
        end else begin
            next_boost      = 1'b0;
            next_boost_held = 1'b0;
        end
    end

    // main output monitor and short-circuit timer
    always_comb begin
        main_uv = !MAIN_ABOVE_LEVEL[MAIN_RESET_THRESHOLD];
        next_short_cnt   = short_cnt;
        next_short_cause = SHORT_CAUSE;
        if (pwr != smm_pkg::SMM_ON || MAIN_ABOVE_SHORT) begin
            next_short_cnt = 32'h0000_0000;
        end else if (short_cnt != 32'(SHORT_CYC)) begin
            next_short_cnt = short_cnt + 32'h0000_0001;
        end
        // latched cause survives until the supply state is back in off
        if (next_short_cnt == 32'(SHORT_CYC)) begin
            next_short_cause = 1'b1;
        end else if (pwr == smm_pkg::SMM_OFF) begin
            next_short_cause = 1'b0;
        end
    end

    // auxiliary regulator and detectors
    always_comb begin
        next_aux_on = 1'b0;
        if (pwr == smm_pkg::SMM_ON && MODE != smm_pkg::SMM_SLEEP &&
            MODE != smm_pkg::SMM_RESET && MODE != smm_pkg::SMM_POWERUP &&
            active_mode(MODE)) begin
            next_aux_on = AUX_ENABLE_BIT;
        end
        next_status.under = AUX_UNDER_RAW && AUX_SUPPLY_ON;
        next_status.over  = AUX_OVER_RAW;
        // set wins over a clear in the same cycle
        next_uf = AUX_UNDER_FLAG && !AUX_FLAG_CLEAR;
        next_of = AUX_OVER_FLAG && !AUX_FLAG_CLEAR;
        if (next_status.under != AUX_STATUS.under) next_uf = 1'b1;
        if (next_status.over != AUX_STATUS.over) next_of = 1'b1;
    end

    // register every group
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            pwr                <= smm_pkg::SMM_OFF;
            boost_held         <= 1'b0;
            BOOST_ACTIVE       <= 1'b0;
            short_cnt          <= 32'h0000_0000;
            SHORT_CAUSE        <= 1'b0;
            MAIN_UNDERVOLT     <= 1'b1;
            MAIN_LOW_WARN_N_OE <= 1'b1;
            AUX_SUPPLY_ON      <= 1'b0;
            AUX_STATUS         <= '0;
            AUX_UNDER_FLAG     <= 1'b0;
            AUX_OVER_FLAG      <= 1'b0;
        end else begin
            pwr                <= next_pwr;
            boost_held         <= next_boost_held;
            BOOST_ACTIVE       <= next_boost;
            short_cnt          <= next_short_cnt;
            SHORT_CAUSE        <= next_short_cause;
            MAIN_UNDERVOLT     <= main_uv;
            MAIN_LOW_WARN_N_OE <= !MAIN_ABOVE_WARN;
            AUX_SUPPLY_ON      <= next_aux_on;
            AUX_STATUS         <= next_status;
            AUX_UNDER_FLAG     <= next_uf;
            AUX_OVER_FLAG      <= next_of;
        end
    end

    // derived outputs; open-drain reset pulls low on under-voltage
    assign CORE_RUN       = (pwr == smm_pkg::SMM_ON);
    assign SHUTDOWN       = (pwr != smm_pkg::SMM_ON);
    assign CONV_ENABLE    = (pwr == smm_pkg::SMM_ON);
    assign RESET_OUT_N_OE = MAIN_UNDERVOLT || !CORE_RUN;
    assign SHORT_FAILSAFE = SHORT_CAUSE;
    assign AUX_IRQ = AUX_IRQ_ENABLE &&
                     (AUX_UNDER_FLAG || AUX_OVER_FLAG);

    // modulation generator; off means fixed frequency
    smm_freq_mod u_fm (
        .SYS_CLK         (SYS_CLK),
        .NRST            (NRST),
        .FM              (FM_CTRL),
        .FREQ_OFFSET_PCT (FREQ_OFFSET_PCT)
    );

    // start only from the idle state; the one shut-down cycle goes to off
    sequence s_mid_on;
        (pwr == smm_pkg::SMM_OFF) && MID_ABOVE_ON;
    endsequence
    property p_start;
        @(posedge SYS_CLK) disable iff (!NRST)
        s_mid_on |=> CORE_RUN && !BOOST_ACTIVE;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_stop;
        @(posedge SYS_CLK) disable iff (!NRST)
        CORE_RUN && !MID_ABOVE_OFF |=> SHUTDOWN;
    endproperty
    a_stop: assert property (p_stop) else $error("no shutdown");
    property p_buck;
        @(posedge SYS_CLK) disable iff (!NRST)
        WAKE_FROM_SLEEP || FAILSAFE_RECOVER |=> !BOOST_ACTIVE;
    endproperty
    a_buck: assert property (p_buck) else $error("boost forced");
    property p_boost;
        @(posedge SYS_CLK) disable iff (!NRST)
        CORE_RUN && MID_ABOVE_OFF && STEP_UP_ENABLE_BIT &&
        active_mode(MODE) && !WAKE_FROM_SLEEP && !FAILSAFE_RECOVER
        |=> BOOST_ACTIVE;
    endproperty
    a_boost: assert property (p_boost) else $error("no boost");
    property p_strap;
        @(posedge SYS_CLK) disable iff (!NRST)
        !SW_DEV_CONFIG && !STEP_UP_ENABLE_BIT |=> !BOOST_ACTIVE ||
        MODE == smm_pkg::SMM_POWERUP;
    endproperty
    a_strap: assert property (p_strap) else $error("strap leak");
    property p_warn;
        @(posedge SYS_CLK) disable iff (!NRST)
        1'b1 |=> MAIN_LOW_WARN_N_OE == !$past(MAIN_ABOVE_WARN);
    endproperty
    a_warn: assert property (p_warn) else $error("warn wrong");
    property p_aux_uv;
        @(posedge SYS_CLK) disable iff (!NRST)
        !AUX_SUPPLY_ON |=> !AUX_STATUS.under;
    endproperty
    a_aux_uv: assert property (p_aux_uv) else $error("uv off");
    property p_flag;
        @(posedge SYS_CLK) disable iff (!NRST)
        $changed(AUX_STATUS.over) |-> AUX_OVER_FLAG ##1
        (AUX_OVER_FLAG || $past(AUX_FLAG_CLEAR));
    endproperty
    a_flag: assert property (p_flag) else $error("flag lost");
    // last cycle of the timer below the short level sets the cause
    property p_short;
        @(posedge SYS_CLK) disable iff (!NRST)
        CORE_RUN && !MAIN_ABOVE_SHORT &&
        short_cnt == 32'(SHORT_CYC - 1) |=> SHORT_FAILSAFE;
    endproperty
    a_short: assert property (p_short) else $error("no failsafe");
    // sleep always turns the auxiliary regulator off
    property p_aux_sleep;
        @(posedge SYS_CLK) disable iff (!NRST)
        MODE == smm_pkg::SMM_SLEEP |=> !AUX_SUPPLY_ON;
    endproperty
    a_aux_sleep: assert property (p_aux_sleep) else $error("aux on");
endmodule : smm_ctrl

/* dv/smm_host_model.sv */
// host controller model: drives the supply control bits of the block
// assumes the bench calls its tasks; all changes land on a rising edge
`timescale 1ns/1ps
module smm_host_model (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic irq,
    output logic      step_up_bit,
    output logic      aux_bit,
    output logic      irq_en,
    output logic      flag_clear
);
    int irq_seen;  // edges with the request up, read by the bench

    // control bits start cleared, as after a host reset
    initial begin
        step_up_bit = 1'b0;
        aux_bit = 1'b0;
        irq_en = 1'b0;
        flag_clear = 1'b0;
        irq_seen = 0;
    end

    // count request cycles; only while out of reset
    always @(posedge sys_clk) begin
        if (nrst && irq) begin
            irq_seen++;
        end
    end

    // host writes boost, aux regulator and irq enable together
    task automatic set_ctrl(input logic b, input logic a, input logic e);
        @(posedge sys_clk);
        step_up_bit <= b;
        aux_bit <= a;
        irq_en <= e;
    endtask : set_ctrl

    // one-cycle clear; a second edge passes before it can rise again
    task automatic clear_flags;
        @(posedge sys_clk);
        flag_clear <= 1'b1;
        @(posedge sys_clk);
        flag_clear <= 1'b0;
    endtask : clear_flags
endmodule : smm_host_model

/* dv/smm_ctrl_tb.sv */
// self-checking bench for the supply mode and monitor controller
// assumes one 100 MHz clock; short detect count shortened to 20
`timescale 1ns/1ps
module smm_ctrl_tb;
    localparam int SHORT = 20;             // short-circuit count in sim
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic mid_on = 1'b0, mid_off = 1'b0;   // mid rail comparators
    smm_pkg::smm_mode_e mode = smm_pkg::SMM_POWERUP;
    logic wake = 1'b0, fsrec = 1'b0, devcfg = 1'b0, strap = 1'b0;
    smm_pkg::smm_fm_s fm = '0;             // modulation off by default
    logic [1:0] thr = 2'h0;                // lowest threshold by default
    logic [3:0] lvl = 4'hF;                // main output above all levels
    logic warn_in = 1'b1, short_in = 1'b1, aux_u = 1'b0, aux_o = 1'b0;
    logic step, auxb, irqen, fclr;         // from the host model
    logic run, shut, conv, boost, uv, rst_oe, warn_oe, sfs, scause;
    logic aux_on, uflag, oflag, irq;
    logic signed [5:0] freq;
    smm_pkg::smm_aux_s aux_st;
    int err_count = 0;
    int num_checks = 0;

    // free running clock, 10 ns period
    always #5 sys_clk = ~sys_clk;

    smm_host_model host_u (.sys_clk(sys_clk), .nrst(nrst), .irq(irq),
        .step_up_bit(step), .aux_bit(auxb), .irq_en(irqen),
        .flag_clear(fclr));

    smm_ctrl #(.SHORT_CYC(SHORT)) dut_u (.SYS_CLK(sys_clk), .NRST(nrst),
        .MID_ABOVE_ON(mid_on), .MID_ABOVE_OFF(mid_off), .MODE(mode),
        .WAKE_FROM_SLEEP(wake), .FAILSAFE_RECOVER(fsrec),
        .STEP_UP_ENABLE_BIT(step), .SW_DEV_CONFIG(devcfg),
        .CFG_STRAP(strap), .FM_CTRL(fm), .MAIN_RESET_THRESHOLD(thr),
        .MAIN_ABOVE_LEVEL(lvl), .MAIN_ABOVE_WARN(warn_in),
        .MAIN_ABOVE_SHORT(short_in), .AUX_ENABLE_BIT(auxb),
        .AUX_UNDER_RAW(aux_u), .AUX_OVER_RAW(aux_o),
        .AUX_FLAG_CLEAR(fclr), .AUX_IRQ_ENABLE(irqen), .CORE_RUN(run),
        .SHUTDOWN(shut), .CONV_ENABLE(conv), .BOOST_ACTIVE(boost),
        .FREQ_OFFSET_PCT(freq), .MAIN_UNDERVOLT(uv),
        .RESET_OUT_N_OE(rst_oe), .MAIN_LOW_WARN_N_OE(warn_oe),
        .SHORT_FAILSAFE(sfs), .SHORT_CAUSE(scause),
        .AUX_SUPPLY_ON(aux_on), .AUX_STATUS(aux_st),
        .AUX_UNDER_FLAG(uflag), .AUX_OVER_FLAG(oflag), .AUX_IRQ(irq));

    // let registered answers land, then sample off the edge
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic chk_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task automatic chk_pct(input string n, input logic signed [5:0] e,
                           input logic signed [5:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %0d seen %0d", n, e, g);
        end
    endtask : chk_pct

    // one place where the run ends
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    // mid rail rises: machine runs, converter on in buck
    task automatic t_power_on;
        @(posedge sys_clk);
        mid_on <= 1'b1;
        mid_off <= 1'b1;
        settle();
        chk_bit("core_run", 1'b1, run);
        chk_bit("conv_enable", 1'b1, conv);
        chk_bit("boost_powerup", 1'b0, boost);
    endtask : t_power_on

    // fixed frequency first, then peak offset for each depth
    task automatic t_freq_mod;
        int pct[3] = '{10, 20, 30};
        logic signed [5:0] hi;
        logic signed [5:0] lo;
        chk_pct("freq_fixed", 6'sh0, freq);
        for (int d = 0; d < 3; d++) begin
            @(posedge sys_clk);
            fm <= '{enable: 1'b1, depth: 2'(d)};
            hi = 6'sh0;
            lo = 6'sh0;
            // two full 10 kHz periods at 100 MHz
            repeat (20000) begin
                @(posedge sys_clk);
                #1;
                if (freq > hi) hi = freq;
                if (freq < lo) lo = freq;
            end
            chk_pct("freq_peak", 6'(pct[d]), hi);
            chk_pct("freq_trough", -6'(pct[d]), lo);
        end
        @(posedge sys_clk);
        fm <= '0;
    endtask : t_freq_mod

    // boost bit in each active mode, kept through powerup, forced off
    task automatic t_boost;
        host_u.set_ctrl(1'b1, 1'b0, 1'b0);
        for (int i = 1; i <= 5; i++) begin
            @(posedge sys_clk);
            mode <= smm_pkg::smm_mode_e'(i);
            settle();
            chk_bit("boost_mode", 1'b1, boost);
        end
        @(posedge sys_clk);
        mode <= smm_pkg::SMM_POWERUP;
        settle();
        chk_bit("boost_uv_recovery", 1'b1, boost);
        @(posedge sys_clk);
        wake <= 1'b1;
        settle();
        chk_bit("boost_wake", 1'b0, boost);
        @(posedge sys_clk);
        wake <= 1'b0;
        fsrec <= 1'b1;
        settle();
        chk_bit("boost_fs_recover", 1'b0, boost);
        @(posedge sys_clk);
        fsrec <= 1'b0;
        mode <= smm_pkg::SMM_NORMAL;
        host_u.set_ctrl(1'b0, 1'b0, 1'b0);
        @(posedge sys_clk);
        strap <= 1'b1;
        settle();
        chk_bit("strap_no_dev", 1'b0, boost);
        @(posedge sys_clk);
        devcfg <= 1'b1;
        settle();
        chk_bit("strap_dev", 1'b1, boost);
        @(posedge sys_clk);
        strap <= 1'b0;
        settle();
        chk_bit("dev_no_strap", 1'b0, boost);
        @(posedge sys_clk);
        devcfg <= 1'b0;
    endtask : t_boost

    // each threshold picks its own comparator; warning is separate
    task automatic t_thresholds;
        for (int t = 0; t < 4; t++) begin
            @(posedge sys_clk);
            thr <= 2'(t);
            lvl <= 4'hF ^ (4'h1 << t);
            settle();
            chk_bit("uv_selected_low", 1'b1, uv);
            chk_bit("reset_out_low", 1'b1, rst_oe);
            @(posedge sys_clk);
            lvl <= 4'h1 << t;
            settle();
            chk_bit("uv_selected_high", 1'b0, uv);
            chk_bit("reset_out_free", 1'b0, rst_oe);
        end
        @(posedge sys_clk);
        lvl <= 4'hF;
        thr <= 2'h0;
        warn_in <= 1'b0;
        settle();
        chk_bit("warn_low", 1'b1, warn_oe);
        chk_bit("warn_not_reset", 1'b0, uv);
        @(posedge sys_clk);
        warn_in <= 1'b1;
        settle();
        chk_bit("warn_free", 1'b0, warn_oe);
    endtask : t_thresholds

    // aux regulator control, detectors, sticky flags, request
    task automatic t_aux;
        host_u.set_ctrl(1'b0, 1'b1, 1'b1);
        settle();
        chk_bit("aux_on", 1'b1, aux_on);
        @(posedge sys_clk);
        aux_u <= 1'b1;
        settle();
        chk_bit("aux_under_st", 1'b1, aux_st.under);
        chk_bit("aux_under_flag", 1'b1, uflag);
        chk_bit("aux_irq", 1'b1, irq);
        @(posedge sys_clk);
        aux_u <= 1'b0;
        settle();
        chk_bit("aux_flag_sticky", 1'b1, uflag);
        host_u.clear_flags();
        settle();
        chk_bit("aux_flag_clear", 1'b0, uflag);
        chk_bit("aux_irq_clear", 1'b0, irq);
        host_u.set_ctrl(1'b0, 1'b0, 1'b0);
        @(posedge sys_clk);
        aux_u <= 1'b1;
        aux_o <= 1'b1;
        settle();
        chk_bit("aux_off", 1'b0, aux_on);
        chk_bit("aux_under_off", 1'b0, aux_st.under);
        chk_bit("aux_over_st", 1'b1, aux_st.over);
        chk_bit("aux_over_flag", 1'b1, oflag);
        chk_bit("aux_irq_masked", 1'b0, irq);
        @(posedge sys_clk);
        aux_u <= 1'b0;
        aux_o <= 1'b0;
        host_u.set_ctrl(1'b0, 1'b1, 1'b0);
        @(posedge sys_clk);
        mode <= smm_pkg::SMM_SLEEP;
        settle();
        chk_bit("aux_sleep", 1'b0, aux_on);
        @(posedge sys_clk);
        mode <= smm_pkg::SMM_RESET;
        settle();
        chk_bit("aux_reset_mode", 1'b0, aux_on);
        chk_bit("irq_seen_by_host", 1'b1, host_u.irq_seen > 0);
        @(posedge sys_clk);
        mode <= smm_pkg::SMM_NORMAL;
    endtask : t_aux

    // short flagged only after the full count, then mid rail collapse
    task automatic t_short_off;
        @(posedge sys_clk);
        short_in <= 1'b0;
        // one edge short of the full count: nothing flagged yet
        repeat (SHORT - 1) @(posedge sys_clk);
        #1;
        chk_bit("short_early", 1'b0, scause);
        @(posedge sys_clk);
        #1;
        chk_bit("short_cause", 1'b1, scause);
        chk_bit("short_failsafe", 1'b1, sfs);
        @(posedge sys_clk);
        mid_on <= 1'b0;
        mid_off <= 1'b0;
        settle();
        chk_bit("shutdown", 1'b1, shut);
        chk_bit("core_stop", 1'b0, run);
        chk_bit("short_cause_off", 1'b0, scause);
    endtask : t_short_off

    // main sequence: reset held three cycles, then the scenarios
    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        chk_bit("reset_shutdown", 1'b1, shut);
        chk_bit("reset_aux_off", 1'b0, aux_on);
        @(posedge sys_clk);
        nrst <= 1'b1;
        t_power_on();
        t_freq_mod();
        t_boost();
        t_thresholds();
        t_aux();
        t_short_off();
        summarize();
    end

    // watchdog: scenarios need about 60200 cycles
    initial begin
        repeat (70000) @(posedge sys_clk);
        err_count++;
        summarize();
    end
endmodule : smm_ctrl_tb
